//--- verilog/fault_manager.v
// Fault supervision for four LED current sink channels.
// Assumes analog comparators on pins, sampled through three flops here.
// Outputs are registered; synchronising adds four clocks of latency.
`timescale 1ns/1ps
`include "fault_consts.vh"
module fault_manager
#(
  parameter NCH = `NUM_CHANNELS
)
(
  input wire clock,
  input wire nrst,
  input wire enable_pin,
  input wire vin_under,
  input wire vin_over,
  input wire temp_over,
  input wire vout_over,
  input wire vout_shorted,
  input wire [NCH-1:0] short_above,
  input wire [NCH-1:0] current_at_target,
  input wire [NCH-1:0] pin_grounded,
  input wire pwm_tick,
  input wire direct_pwm,
  input wire transient,
  output reg [NCH-1:0] channel_on_reg,
  output reg boost_run_reg,
  output reg [NCH-1:0] good_reg,
  output reg [NCH-1:0] failed_reg,
  output reg latched_off_reg
);
  // Device states and width of the synchronised flag vector
  localparam ST_OFF = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam ST_LATCH = 2'h3;
  localparam NIN = 5 + 3 * NCH;

  // Three flop sampling of the analog flags; second and third must agree
  // The filter keeps its value while they differ, so a glitch is ignored
  wire [NIN-1:0] raw;
  reg [NIN-1:0] s1_reg;
  reg [NIN-1:0] s2_reg;
  reg [NIN-1:0] s3_reg;
  reg [NIN-1:0] flt_reg;
  assign raw = {enable_pin, vin_under, vin_over, temp_over, vout_over,
    pin_grounded, short_above, current_at_target};
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_reg <= {NIN{1'b0}};
      s2_reg <= {NIN{1'b0}};
      s3_reg <= {NIN{1'b0}};
      flt_reg <= {NIN{1'b0}};
    end
    else
    begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      flt_reg <= (s2_reg & s3_reg) | (flt_reg & (s2_reg | s3_reg));
    end
  end

  wire en_f = flt_reg[NIN-1];
  wire uv_f = flt_reg[NIN-2];
  wire ov_in_f = flt_reg[NIN-3];
  wire ot_f = flt_reg[NIN-4];
  wire ovp_f = flt_reg[NIN-5];
  wire [NCH-1:0] short_f = flt_reg[2*NCH-1:NCH];
  // Grounded-pin map filtered like the rest, read only while off
  wire [NCH-1:0] gnd_f = flt_reg[3*NCH-1:2*NCH];
  wire [NCH-1:0] cur_f = flt_reg[NCH-1:0];

  // Timers are held clear outside run; direct PWM stretches the count
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [NCH-1:0] used_reg;
  wire run = (state_reg == ST_RUN);
  wire clear_all = !run;
  wire [3:0] extra = direct_pwm ? `DIRECT_EXTRA_CYCLES : 4'h0;

  // Per-channel fault timers for short and open conditions
  wire [NCH-1:0] short_exp;
  wire [NCH-1:0] open_exp;
  wire [NCH-1:0] open_fault;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : ch
      // Lost current after good, or not good during overvoltage
      assign open_fault[g] = used_reg[g] && !failed_reg[g] &&
        ((good_reg[g] && !cur_f[g]) || (ovp_f && !good_reg[g]));
      channel_timer #(.LIMIT(`TIMEOUT_PWM_CYCLES)) st
      (
        .clock(clock),
        .nrst(nrst),
        .clear(clear_all || failed_reg[g]),
        .fault(used_reg[g] && short_f[g]),
        .hold(transient),
        .pwm_tick(pwm_tick),
        .limit_add(extra),
        .expired_reg(short_exp[g])
      );
      // Open timer runs beside the short timer of the same string
      channel_timer #(.LIMIT(`TIMEOUT_PWM_CYCLES)) ot
      (
        .clock(clock),
        .nrst(nrst),
        .clear(clear_all || failed_reg[g]),
        .fault(open_fault[g]),
        .hold(transient),
        .pwm_tick(pwm_tick),
        .limit_add(extra),
        .expired_reg(open_exp[g])
      );
    end
  endgenerate

  // Count channels already down (failed or unused)
  reg [2:0] down_cnt;
  integer i;
  always @*
  begin
    down_cnt = 3'h0;
    for (i = 0; i < NCH; i = i + 1)
      down_cnt = down_cnt + {2'h0, failed_reg[i] | !used_reg[i]};
  end
  // Kill only when this short would leave no other string running
  wire kill_all = |(short_exp & ~failed_reg) && (down_cnt >= `DOWN_LIMIT);

  // Device state: off, start-up check, run, latched off
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:
        // Start only once enabled and above the lockout level
        if (en_f && !uv_f)
          state_next = ST_START;
      ST_START:
        // A trip during start-up latches as it would in run
        if (ot_f || ov_in_f)
          state_next = ST_LATCH;
        else if (!vout_shorted)
          state_next = ST_RUN;
      ST_RUN:
        if (ot_f || ov_in_f)
          state_next = ST_LATCH;
      ST_LATCH:
        // Left only through the enable override below
        state_next = ST_LATCH;
      default:
        state_next = ST_OFF;
    endcase
    // Enable low overrides every state; lockout overrides every state but latched off
    if (!en_f)
      state_next = ST_OFF;
    else if (uv_f && state_reg != ST_LATCH)
      state_next = ST_OFF;
  end

  // Strings dropping out at this edge; a kill takes every string
  wire [NCH-1:0] drop_now = kill_all ? {NCH{1'b1}} :
    (short_exp | open_exp);

  // Next values of the channel flags and outputs
  reg [NCH-1:0] used_next;
  reg [NCH-1:0] good_next;
  reg [NCH-1:0] failed_next;
  reg [NCH-1:0] channel_on_next;
  reg boost_run_next;
  reg latched_off_next;
  always @*
  begin
    used_next = used_reg;
    good_next = good_reg;
    failed_next = failed_reg;
    if (state_reg == ST_OFF)
    begin
      // Defaults restored whenever off; grounded pins taken at start
      used_next = ~gnd_f;
      good_next = {NCH{1'b0}};
      failed_next = {NCH{1'b0}};
    end
    else if (run)
    begin
      // Good is sticky, so a later loss of current reads as open
      good_next = good_reg | (cur_f & used_reg);
      failed_next = failed_reg | drop_now;
    end
    // Sinks conduct only in run and never on a dropped string
    if (state_next == ST_RUN)
      channel_on_next = used_reg & ~failed_reg & ~drop_now;
    else
      channel_on_next = {NCH{1'b0}};
    // Boost waits while the output is shorted to ground
    boost_run_next = (state_next == ST_RUN) && !vout_shorted;
    latched_off_next = (state_next == ST_LATCH);
  end

  // State, channel flags and outputs
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ST_OFF;
      used_reg <= {NCH{1'b0}};
      good_reg <= {NCH{1'b0}};
      failed_reg <= {NCH{1'b0}};
      channel_on_reg <= {NCH{1'b0}};
      boost_run_reg <= 1'b0;
      latched_off_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      used_reg <= used_next;
      good_reg <= good_next;
      failed_reg <= failed_next;
      channel_on_reg <= channel_on_next;
      boost_run_reg <= boost_run_next;
      latched_off_reg <= latched_off_next;
    end
  end
endmodule

//--- verilog/fault_consts.vh
// Constants for the LED string fault manager.
// Assumes a 250 MHz logic clock and PWM cycle ticks from the dimming logic.
`ifndef FAULT_CONSTS_VH
`define FAULT_CONSTS_VH
`define TIMEOUT_PWM_CYCLES 4'h6
`define DIRECT_EXTRA_CYCLES 4'h2
`define DOWN_LIMIT 3'h3
`define NUM_CHANNELS 4
`endif

//--- verilog/channel_timer.v
// One channel's fault timeout counter in PWM cycles.
// Assumes pwm_tick is a one-cycle pulse at each PWM cycle boundary.
`timescale 1ns/1ps
`include "fault_consts.vh"
module channel_timer
#(
  parameter LIMIT = `TIMEOUT_PWM_CYCLES
)
(
  input wire clock,
  input wire nrst,
  input wire clear,
  input wire fault,
  input wire hold,
  input wire pwm_tick,
  input wire [3:0] limit_add,
  output reg expired_reg
);
  reg [3:0] count_reg;
  reg [3:0] count_next;
  reg expired_next;
  wire [3:0] target;

  assign target = LIMIT + limit_add;

  // Count ticks while the fault stands
  always @*
  begin
    count_next = count_reg;
    expired_next = expired_reg;
    if (clear)
    begin
      count_next = 4'h0;
      expired_next = 1'b0;
    end
    else if (!fault)
      count_next = 4'h0;
    else if (pwm_tick && !hold && !expired_reg)
    begin
      if (count_reg + 4'h1 >= target)
        expired_next = 1'b1;
      else
        count_next = count_reg + 4'h1;
    end
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      count_reg <= 4'h0;
      expired_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      expired_reg <= expired_next;
    end
  end
endmodule

//--- dv/sensor_model.sv
// Behavioural stand-in for the analog string sensing and boost stage.
// Assumes commands from the bench pick which strings are shorted or open.
`timescale 1ns/1ps
module sensor_model
(
  input wire [3:0] channel_on,
  input wire [3:0] short_cmd,
  input wire [3:0] open_cmd,
  output wire [3:0] short_above,
  output wire [3:0] current_at_target,
  output wire vout_over
);
  // Shorted string reads far above the rest only while its sink conducts
  assign short_above = short_cmd & channel_on;
  // Open string never reaches target, so boost climbs to its limit
  assign current_at_target = channel_on & ~open_cmd;
  assign vout_over = |(channel_on & open_cmd);
endmodule

//--- dv/fault_manager_chk_chk.sv
// Port-level checks for the LED string fault manager.
// Assumes it is bound into fault_manager and sees only its ports.
`timescale 1ns/1ps
module fault_manager_chk
#(
  parameter NCH = 4
)
(
  input wire clock,
  input wire nrst,
  input wire enable_pin,
  input wire vin_under,
  input wire vin_over,
  input wire temp_over,
  input wire vout_shorted,
  input wire transient,
  input wire [NCH-1:0] pin_grounded,
  input wire [NCH-1:0] channel_on_reg,
  input wire [NCH-1:0] failed_reg,
  input wire boost_run_reg,
  input wire latched_off_reg
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Trip held long enough to pass the synchroniser
  sequence s_trip;
    ((temp_over || vin_over) && boost_run_reg)[*4];
  endsequence
  chk_off_quiet:
    assert property ((!enable_pin)[*8] |-> !boost_run_reg && !channel_on_reg)
      else $error("active while disabled");
  chk_trip_latch:
    assert property (s_trip |-> ##[0:8] latched_off_reg)
      else $error("trip did not latch");
  chk_dark_latch:
    assert property (latched_off_reg && $past(latched_off_reg)
      |-> !boost_run_reg && !channel_on_reg) else $error("latched but on");
  chk_under_stop:
    assert property (vin_under[*8] |-> !boost_run_reg && !channel_on_reg)
      else $error("runs in undervoltage");
  chk_fail_dark:
    assert property (!(failed_reg & channel_on_reg))
      else $error("failed channel on");
  chk_short_hold:
    assert property ((!boost_run_reg && vout_shorted)[*2] |=> !boost_run_reg)
      else $error("boost with shorted output");
  chk_freeze_timer:
    assert property ((transient && enable_pin)[*8] |-> $stable(failed_reg))
      else $error("fault during transient");
  chk_ground_skip:
    assert property ($past(channel_on_reg) == 0 && $stable(pin_grounded)
      |-> !(channel_on_reg & pin_grounded)) else $error("grounded pin on");
endmodule
bind fault_manager fault_manager_chk #(.NCH(NCH)) chk_i(.*);

//--- dv/tb.sv
// Self-checking bench for fault_manager with a simple expected model.
// Assumes sensor_model on the far side; inputs change on falling edges.
`timescale 1ns/1ps
`define CHK(a,b) begin samples_checked++; if ((a)!==(b)) begin errors++; \
$display("MISMATCH %0t %h %h",$time,a,b); end end
module tb;
  reg clock=0, nrst=0, en=1, uv=0, ov=0, ot=0, vs=0, tk=0, dp=0, tr=0;
  reg [3:0] sh=4'h0, op=4'h0, gnd=4'h8, exp=4'h0, gex=4'h7;
  wire [3:0] sa, cat, on, fl, gd;
  wire vo, br, lo;
  integer errors=0, samples_checked=0, seed=32'hA63F83B9, i;
  always #2 clock=~clock;
  fault_manager DUT(.clock(clock),.nrst(nrst),.enable_pin(en),
    .vin_under(uv),.vin_over(ov),.temp_over(ot),.vout_over(vo),
    .vout_shorted(vs),.short_above(sa),.current_at_target(cat),
    .pin_grounded(gnd),.pwm_tick(tk),.direct_pwm(dp),.transient(tr),
    .channel_on_reg(on),.boost_run_reg(br),.good_reg(gd),.failed_reg(fl),
    .latched_off_reg(lo));
  sensor_model P(.channel_on(on),.short_cmd(sh),.open_cmd(op),
    .short_above(sa),.current_at_target(cat),.vout_over(vo));
  task cyc(input integer n); repeat (n) @(negedge clock); endtask
  // Random gaps between dimming ticks
  task tick(input integer n);
    repeat (n)
    begin
      tk=1; cyc(1); tk=0; cyc(2+($random(seed)&7));
    end
  endtask
  // Sinks follow the model: failed and grounded strings stay dark
  task chk;
    `CHK(on,~exp&~gnd)
    `CHK(fl|gnd,exp|gnd)
    `CHK(gd,gex)
  endtask
  task tally_and_finish;
    if (errors==0 && samples_checked>0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #100000 errors++;
    tally_and_finish();
  end
  initial
  begin
    cyc(5); nrst=1; cyc(12); chk();
    sh=4'h2; cyc(8); tick(3); sh=0; cyc(8);
    sh=4'h2; cyc(8); tick(5); cyc(4); chk();
    tr=1; tick(3); cyc(4); chk(); tr=0; cyc(8);
    tick(1); cyc(4); exp=4'h2; chk();
    dp=1; sh=0; op=4'h4; cyc(8); tick(7); cyc(4); chk();
    tick(1); cyc(4); exp=4'h6; chk();
    dp=0; op=0; sh=4'h1; cyc(8); tick(6); cyc(4); exp=4'hF; chk();
    sh=0;
    // Each chip-wide cause, then release and enable cycling
    for (i=0; i<3; i++)
    begin
      uv=(i==0); ot=(i==1); ov=(i==2); cyc(10);
      `CHK(on,4'h0)
      `CHK(lo,i>0)
      uv=0; ot=0; ov=0; cyc(12);
      `CHK(br,i==0)
      `CHK(on,(i==0)?~gnd:4'h0)
      en=0; cyc(10); `CHK(lo,1'b0)
      `CHK(br,1'b0)
      `CHK(gd,4'h0)
      en=1; cyc(12); exp=0; chk();
    end
    // String open from start-up never turns good, times out on overvoltage
    en=0; cyc(10); op=4'h1; gex=4'h6; en=1; cyc(12); chk();
    tick(5); cyc(4); chk();
    tick(1); cyc(4); exp=4'h1; chk();
    op=0;
    nrst=0; vs=1; cyc(5); nrst=1; cyc(12); `CHK(br,1'b0)
    tally_and_finish();
  end
endmodule
